//--- hw/reset_and_shared_pin_ownership.v
`timescale 1ns/1ps
`include "reset_pin_defines.vh"

// Function
// - reset low holds device in reset
// - boot mode captured at reset release
// - core reset lifts after fixed clock count
// - reset without trst spares debug logic
// - master data leads sampling edge half cycle
// - slave mode makes data pin an input
// - select pin arbitrates master, selects slave
// - data and select pins default serial receive
// - spi clock drives as master, inputs as slave
// - spi clock pin defaults to spi clock
// - gpio direction set per pin by software
// - receive clock pin bidirectional, continuous or gated
// - sync mode shares receive clock with transmitter while gpio does not own the receive clock pin
// - receive clock pin defaults to gpio input
// - gpio owned pin may switch pull-up off
module reset_and_shared_pin_ownership (
  input wire sys_clk,
  input wire rstn,
  input wire trstn,
  input wire bootModePin,
  output wire coreRstn,
  output wire debugRstn,
  output wire bootMode,
  input wire spi1Enable,
  input wire spi1Master,
  input wire spi1MasterOutSlaveInOut,
  output wire spi1MasterOutSlaveIn,
  output reg spi1ModeFault,
  output reg spi1SlaveSelected,
  output wire serial0ReceiveIn,
  output wire serial1ReceiveIn,
  input wire spiClockGpioSel,
  input wire spiMaster,
  input wire spiClockOut,
  output wire spiClockIn,
  input wire portFBit4Out,
  input wire portFBit4Dir,
  input wire portFBit4PullupOff,
  output wire portFBit4In,
  input wire rxClockGpioSel,
  input wire syncSerialRxClockDrive,
  input wire syncSerialRxClockOut,
  input wire syncSerialSyncMode,
  input wire syncSerialTxClockIn,
  output wire syncSerialReceiveClock,
  output reg syncSerialTxBitClock,
  input wire portCBit2Out,
  input wire portCBit2Dir,
  input wire portCBit2PullupOff,
  output wire portCBit2In,
  input wire dataPadIn,
  output wire dataPadOut,
  output wire dataPadOe,
  output wire dataPadPullupEn,
  input wire selectPadIn,
  output wire selectPadOut,
  output wire selectPadOe,
  output wire selectPadPullupEn,
  input wire spiClockPadIn,
  output wire spiClockPadOut,
  output wire spiClockPadOe,
  output wire spiClockPadPullupEn,
  input wire rxClockPadIn,
  output wire rxClockPadOut,
  output wire rxClockPadOe,
  output wire rxClockPadPullupEn
);

  reg [`PAD_MSB:0] ownSel; // 1 = secondary side owns the pad
  reg [`PAD_MSB:0] next_ownSel; // ownership requested by software
  reg portFDir; // gpio direction of the spi clock pin
  reg portCDir; // gpio direction of the receive clock pin
  reg [`PAD_MSB:0] periphOut; // peripheral drive value per pad
  reg [`PAD_MSB:0] periphOe; // peripheral drive enable per pad
  reg [`PAD_MSB:0] gpioOut; // secondary side drive value per pad
  reg [`PAD_MSB:0] gpioOe; // secondary side drive enable per pad
  reg [`PAD_MSB:0] gpioPullupOff; // secondary side pull-up switch
  wire [`PAD_MSB:0] padIn; // pad levels gathered
  wire [`PAD_MSB:0] padOut; // pad drive values gathered
  wire [`PAD_MSB:0] padOe; // pad enables gathered
  wire [`PAD_MSB:0] padPullupEn; // pad pull-ups gathered
  wire [`PAD_MSB:0] periphIn; // registered pad level, peripheral view
  wire [`PAD_MSB:0] gpioIn; // registered pad level, secondary view
  wire spi1Owns; // second spi holds the data and select pins
  wire selectLow; // select pin seen asserted

  // true when the peripheral side, not the secondary, owns a pad
  function periphOwns;
    input [`PAD_MSB:0] sel;
    input integer idx;
    begin
      periphOwns = ~sel[idx];
    end
  endfunction

  // reset entry, stretched release, boot strap and debug reset split
  reset_sequencer resetSeq (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .trstn(trstn),
    .bootModePin(bootModePin),
    .coreRstn(coreRstn),
    .debugRstn(debugRstn),
    .bootMode(bootMode)
  );

  // ownership request: data and select follow the second spi enable
  always @* begin
    next_ownSel = `OWN_RESET;
    next_ownSel[`PAD_SPI1_DATA] = ~spi1Enable;
    next_ownSel[`PAD_SPI1_SELECT] = ~spi1Enable;
    next_ownSel[`PAD_SPI_CLOCK] = spiClockGpioSel;
    next_ownSel[`PAD_RX_CLOCK] = rxClockGpioSel;
  end

  // ownership and gpio direction keep defaults while the core is held
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ownSel <= `OWN_RESET;
      portFDir <= `GPIO_DIR_RESET;
      portCDir <= `GPIO_DIR_RESET;
    end else if (!coreRstn) begin
      // core still in reset: pins stay with their default owners
      ownSel <= `OWN_RESET;
      portFDir <= `GPIO_DIR_RESET;
      portCDir <= `GPIO_DIR_RESET;
    end else begin
      ownSel <= next_ownSel;
      portFDir <= portFBit4Dir;
      portCDir <= portCBit2Dir;
    end
  end

  // peripheral side drive for each shared pad
  always @* begin
    periphOut = {`PAD_COUNT{1'b0}};
    periphOe = {`PAD_COUNT{1'b0}};
    // data pin: master drives, slave listens
    periphOut[`PAD_SPI1_DATA] = spi1MasterOutSlaveInOut;
    periphOe[`PAD_SPI1_DATA] = spi1Master;
    // select pin is input in both modes
    periphOut[`PAD_SPI1_SELECT] = 1'b0;
    periphOe[`PAD_SPI1_SELECT] = 1'b0;
    // spi clock out as master, in as slave
    periphOut[`PAD_SPI_CLOCK] = spiClockOut;
    periphOe[`PAD_SPI_CLOCK] = spiMaster;
    // receive clock: direction chosen by the sync serial port
    periphOut[`PAD_RX_CLOCK] = syncSerialRxClockOut;
    periphOe[`PAD_RX_CLOCK] = syncSerialRxClockDrive;
  end

  // secondary side drive: serial receive never drives, gpio does
  always @* begin
    gpioOut = {`PAD_COUNT{1'b0}};
    gpioOe = {`PAD_COUNT{1'b0}};
    gpioPullupOff = {`PAD_COUNT{1'b0}};
    // spi clock pin as port f bit 4
    gpioOut[`PAD_SPI_CLOCK] = portFBit4Out;
    gpioOe[`PAD_SPI_CLOCK] = portFDir;
    gpioPullupOff[`PAD_SPI_CLOCK] = portFBit4PullupOff;
    // receive clock pin as port c bit 2
    gpioOut[`PAD_RX_CLOCK] = portCBit2Out;
    gpioOe[`PAD_RX_CLOCK] = portCDir;
    gpioPullupOff[`PAD_RX_CLOCK] = portCBit2PullupOff;
  end

  // gather pad inputs in index order
  assign padIn[`PAD_SPI1_DATA] = dataPadIn;
  assign padIn[`PAD_SPI1_SELECT] = selectPadIn;
  assign padIn[`PAD_SPI_CLOCK] = spiClockPadIn;
  assign padIn[`PAD_RX_CLOCK] = rxClockPadIn;

  // one ownership mux per shared pad; data and clock share one
  // register stage so their half-cycle spacing is kept
  genvar p;
  generate
    for (p = 0; p < `PAD_COUNT; p = p + 1) begin : padGen
      shared_pad_owner owner (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .gpioOwns(ownSel[p]),
        .periphOut(periphOut[p]),
        .periphOe(periphOe[p]),
        .gpioOut(gpioOut[p]),
        .gpioOe(gpioOe[p]),
        .gpioPullupOff(gpioPullupOff[p]),
        .padIn(padIn[p]),
        .padOut(padOut[p]),
        .padOe(padOe[p]),
        .padPullupEn(padPullupEn[p]),
        .periphIn(periphIn[p]),
        .gpioIn(gpioIn[p])
      );
    end
  endgenerate

  // pad drive back out to the pins
  assign dataPadOut = padOut[`PAD_SPI1_DATA];
  assign dataPadOe = padOe[`PAD_SPI1_DATA];
  assign dataPadPullupEn = padPullupEn[`PAD_SPI1_DATA];
  assign selectPadOut = padOut[`PAD_SPI1_SELECT];
  assign selectPadOe = padOe[`PAD_SPI1_SELECT];
  assign selectPadPullupEn = padPullupEn[`PAD_SPI1_SELECT];
  assign spiClockPadOut = padOut[`PAD_SPI_CLOCK];
  assign spiClockPadOe = padOe[`PAD_SPI_CLOCK];
  assign spiClockPadPullupEn = padPullupEn[`PAD_SPI_CLOCK];
  assign rxClockPadOut = padOut[`PAD_RX_CLOCK];
  assign rxClockPadOe = padOe[`PAD_RX_CLOCK];
  assign rxClockPadPullupEn = padPullupEn[`PAD_RX_CLOCK];

  // pad levels to every listener, owner or not
  assign spi1MasterOutSlaveIn = periphIn[`PAD_SPI1_DATA];
  assign serial0ReceiveIn = gpioIn[`PAD_SPI1_DATA];
  assign serial1ReceiveIn = gpioIn[`PAD_SPI1_SELECT];
  assign spiClockIn = periphIn[`PAD_SPI_CLOCK];
  assign portFBit4In = gpioIn[`PAD_SPI_CLOCK];
  assign syncSerialReceiveClock = periphIn[`PAD_RX_CLOCK];
  assign portCBit2In = gpioIn[`PAD_RX_CLOCK];

  assign spi1Owns = periphOwns(ownSel, `PAD_SPI1_SELECT);
  assign selectLow = ~periphIn[`PAD_SPI1_SELECT];

  // select pin meaning depends on master or slave mode
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      spi1ModeFault <= 1'b0;
      spi1SlaveSelected <= 1'b0;
    end else begin
      // another master pulled select low: arbitration lost
      spi1ModeFault <= spi1Owns & spi1Master & selectLow;
      // slave addressed while select is low
      spi1SlaveSelected <= spi1Owns & ~spi1Master & selectLow;
    end
  end

  // transmit bit clock: shared receive clock in sync mode unless gpio owns the receive clock pin
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      syncSerialTxBitClock <= 1'b0;
    end else if (syncSerialSyncMode &
        periphOwns(ownSel, `PAD_RX_CLOCK)) begin
      syncSerialTxBitClock <= periphIn[`PAD_RX_CLOCK];
    end else begin
      syncSerialTxBitClock <= syncSerialTxClockIn;
    end
  end

endmodule // reset_and_shared_pin_ownership

//--- hw/reset_sequencer.v
`timescale 1ns/1ps
`include "reset_pin_defines.vh"

module reset_sequencer (
  input wire sys_clk,
  input wire rstn,
  input wire trstn,
  input wire bootModePin,
  output reg coreRstn,
  output reg debugRstn,
  output reg bootMode
);

  localparam ST_HOLD = 2'b00; // waiting for synchronised release
  localparam ST_COUNT = 2'b01; // stretching the internal reset
  localparam ST_RUN = 2'b10; // core out of reset

  reg [1:0] relSync; // release synchroniser, [0] only feeds [1]
  reg [1:0] state; // sequencer state
  reg [`RST_CNT_MSB:0] count; // stretch counter

  // bring the release of the external reset onto the internal clock
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      relSync <= `RST_SYNC_RESET;
    end else begin
      relSync <= {relSync[0], 1'b1};
    end
  end

  // hold, capture boot mode, stretch, then release the core reset
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_HOLD;
      count <= {(`RST_CNT_MSB + 1){1'b0}};
      coreRstn <= 1'b0;
      bootMode <= `BOOT_MODE_RESET;
    end else begin
      case (state)
        ST_HOLD: begin
          if (relSync[1]) begin
            bootMode <= bootModePin;
            count <= {(`RST_CNT_MSB + 1){1'b0}};
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          // release lands on a clock edge after a fixed count
          if (count == `RST_STRETCH_LAST) begin
            coreRstn <= 1'b1;
            state <= ST_RUN;
          end else begin
            count <= count + 1'b1;
          end
        end
        ST_RUN: begin
          coreRstn <= 1'b1;
        end
        default: begin
          state <= ST_HOLD;
          coreRstn <= 1'b0;
        end
      endcase
    end
  end

  // debug logic follows only the test reset, never the processor reset
  always @(posedge sys_clk or negedge trstn) begin
    if (!trstn) begin
      debugRstn <= 1'b0;
    end else begin
      debugRstn <= 1'b1;
    end
  end

endmodule // reset_sequencer

//--- hw/shared_pad_owner.v
`timescale 1ns/1ps
`include "reset_pin_defines.vh"

module shared_pad_owner (
  input wire sys_clk,
  input wire rstn,
  input wire gpioOwns,
  input wire periphOut,
  input wire periphOe,
  input wire gpioOut,
  input wire gpioOe,
  input wire gpioPullupOff,
  input wire padIn,
  output reg padOut,
  output reg padOe,
  output reg padPullupEn,
  output reg periphIn,
  output reg gpioIn
);

  // owner picks the pad drive; both sides always see the pad level
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      padOut <= `PAD_OUT_RESET;
      padOe <= `PAD_OE_RESET;
      padPullupEn <= `PAD_PULLUP_RESET;
      periphIn <= `PAD_IN_RESET;
      gpioIn <= `PAD_IN_RESET;
    end else begin
      if (gpioOwns) begin
        padOut <= gpioOut;
        padOe <= gpioOe;
        padPullupEn <= ~gpioPullupOff;
      end else begin
        padOut <= periphOut;
        padOe <= periphOe;
        padPullupEn <= 1'b1;
      end
      // inactive side gets input only, never drive
      periphIn <= padIn;
      gpioIn <= padIn;
    end
  end

endmodule // shared_pad_owner

//--- shared/reset_pin_defines.vh
`ifndef RESET_PIN_DEFINES_VH
`define RESET_PIN_DEFINES_VH

// internal clocks counted after the external reset is released
`define RST_STRETCH_CYCLES 8'h40
// last count value before the core reset lifts
`define RST_STRETCH_LAST 8'h3F
// width of the stretch counter, as msb index
`define RST_CNT_MSB 7
// two-stage release synchroniser reset value
`define RST_SYNC_RESET 2'h0
// boot mode value held while in reset
`define BOOT_MODE_RESET 1'h0

// pad indices inside the ownership vectors
`define PAD_SPI1_DATA 0
`define PAD_SPI1_SELECT 1
`define PAD_SPI_CLOCK 2
`define PAD_RX_CLOCK 3
`define PAD_COUNT 4
`define PAD_MSB 3

// ownership bit: 1 = secondary side (serial rx or gpio) owns the pad
// after reset: data/select -> serial rx, spi clock -> spi, rx clock -> gpio
`define OWN_RESET 4'hB
// gpio direction after reset is input
`define GPIO_DIR_RESET 1'h0

// pad output state during reset
`define PAD_OUT_RESET 1'h0
`define PAD_OE_RESET 1'h0
`define PAD_PULLUP_RESET 1'h1
`define PAD_IN_RESET 1'h1

`endif

//--- testbench/pad_partner.sv
`timescale 1ns/1ps
// far side of the four shared pads: peripherals, pull-ups, floating lines
module pad_partner (
  input wire sys_clk,
  input wire [3:0] oe,
  input wire [3:0] out,
  input wire [3:0] pullEn,
  input wire [3:0] extEn,
  input wire [3:0] extVal,
  output wire [3:0] level
);
  reg flip = 1'b0; // pattern on a floating pad, changes every cycle
  // toggles so a stale level never looks valid
  always @(posedge sys_clk) begin
    flip <= ~flip;
  end
  // device drive wins, then the peripheral, then pull-up or float
  assign level = (oe & out) | (~oe & extEn & extVal) |
    (~oe & ~extEn & (pullEn | {4{flip}}));
endmodule // pad_partner

//--- testbench/reset_pin_checker_asserts.sv
`timescale 1ns/1ps
// watches reset release and pad ownership at the top ports
module reset_pin_checker (
  input wire sys_clk,
  input wire rstn,
  input wire trstn,
  input wire coreRstn,
  input wire debugRstn,
  input wire spi1Enable,
  input wire spi1Master,
  input wire spi1MasterOutSlaveInOut,
  input wire spiClockGpioSel,
  input wire portFBit4PullupOff,
  input wire spiClockPadIn,
  input wire spiClockIn,
  input wire dataPadOut,
  input wire dataPadOe,
  input wire selectPadOe,
  input wire spiClockPadPullupEn
);
  reg [7:0] upCnt; // cycles since reset release, saturating
  // counts from the release of the external reset
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      upCnt <= 8'h00;
    end else if (upCnt != 8'hFF) begin
      upCnt <= upCnt + 8'h01;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  core_early_a: assert property (upCnt < 8'h3E |-> !coreRstn)
    else $error("core reset lifted too early");
  core_late_a: assert property ($rose(coreRstn) |->
    upCnt >= 8'h3E && upCnt <= 8'h46) else $error("core reset timing");
  debug_keep_a: assert property (disable iff (!trstn)
    $past(trstn) |-> debugRstn) else $error("debug reset without trst");
  select_input_a: assert property (!selectPadOe)
    else $error("select pad driven");
  serial_quiet_a: assert property ((!spi1Enable)[*3] |-> !dataPadOe)
    else $error("serial receive pad driven");
  slave_input_a: assert property ((spi1Enable && !spi1Master)[*3]
    |-> !dataPadOe) else $error("slave data pad driven");
  master_drive_a: assert property ((coreRstn && spi1Enable &&
    spi1Master)[*3] |-> dataPadOe && dataPadOut == $past(
    spi1MasterOutSlaveInOut)) else $error("master data not driven");
  pull_gpio_a: assert property ((coreRstn && spiClockGpioSel &&
    portFBit4PullupOff)[*3] |-> !spiClockPadPullupEn)
    else $error("pull-up not switched off");
  pull_periph_a: assert property ((!spiClockGpioSel)[*3]
    |-> spiClockPadPullupEn) else $error("peripheral pull-up off");
  clock_listen_a: assert property ($past(rstn) |->
    spiClockIn == $past(spiClockPadIn)) else $error("clock pad not seen");
  cover property ($rose(coreRstn));
  cover property (spi1Enable && spi1Master && dataPadOe);
  cover property (spiClockGpioSel && !spiClockPadPullupEn);
endmodule // reset_pin_checker

//--- testbench/tb_reset_and_shared_pin_ownership.sv
`timescale 1ns/1ps
// random ownership configurations compared with a pad model
module tb_reset_and_shared_pin_ownership;
  reg sys_clk = 1'b0;
  reg rstn = 1'b0; // held with trstn for a full reset
  reg trstn = 1'b0;
  reg bootModePin = 1'b1;
  reg [16:0] cfg = 17'h0050B; // non-default config during reset
  reg [3:0] extEn = 4'h0; // peripheral drives a pad
  reg [3:0] extVal = 4'h0; // level it drives
  reg [31:0] rnd = 32'h0000001E; // random source
  reg [3:0] lv; // pad levels before the checked edge
  wire [3:0] oe, out, pull, level;
  wire coreRstn, debugRstn, bootMode, moIn, fault, selected;
  wire rx0, rx1, sclkIn, f4In, rxClk, txBit, c2In;
  integer fail_count = 0;
  integer total_checks = 0;
  integer cycles = 0;
  integer n, k;
  always #25 sys_clk = ~sys_clk;
  reset_and_shared_pin_ownership dut (
    .sys_clk, .rstn, .trstn, .bootModePin, .coreRstn, .debugRstn,
    .bootMode, .spi1Enable(cfg[0]), .spi1Master(cfg[1]),
    .spi1MasterOutSlaveInOut(cfg[2]), .spi1MasterOutSlaveIn(moIn),
    .spi1ModeFault(fault), .spi1SlaveSelected(selected),
    .serial0ReceiveIn(rx0), .serial1ReceiveIn(rx1),
    .spiClockGpioSel(cfg[3]), .spiMaster(cfg[4]), .spiClockOut(cfg[5]),
    .spiClockIn(sclkIn), .portFBit4Out(cfg[6]), .portFBit4Dir(cfg[7]),
    .portFBit4PullupOff(cfg[8]), .portFBit4In(f4In),
    .rxClockGpioSel(cfg[9]), .syncSerialRxClockDrive(cfg[10]),
    .syncSerialRxClockOut(cfg[11]), .syncSerialSyncMode(cfg[12]),
    .syncSerialTxClockIn(cfg[13]), .syncSerialReceiveClock(rxClk),
    .syncSerialTxBitClock(txBit), .portCBit2Out(cfg[14]),
    .portCBit2Dir(cfg[15]), .portCBit2PullupOff(cfg[16]),
    .portCBit2In(c2In), .dataPadIn(level[0]), .dataPadOut(out[0]),
    .dataPadOe(oe[0]), .dataPadPullupEn(pull[0]), .selectPadIn(level[1]),
    .selectPadOut(out[1]), .selectPadOe(oe[1]),
    .selectPadPullupEn(pull[1]), .spiClockPadIn(level[2]),
    .spiClockPadOut(out[2]), .spiClockPadOe(oe[2]),
    .spiClockPadPullupEn(pull[2]), .rxClockPadIn(level[3]),
    .rxClockPadOut(out[3]), .rxClockPadOe(oe[3]),
    .rxClockPadPullupEn(pull[3])
  );
  pad_partner far (.sys_clk(sys_clk), .oe(oe), .out(out), .pullEn(pull),
    .extEn(extEn), .extVal(extVal), .level(level));
  // shift register step for random values
  function [31:0] nextRand(input [31:0] v);
    nextRand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // pads the device should drive for a configuration
  function [3:0] expOe(input [16:0] c);
    expOe = {c[9] ? c[15] : c[10], c[3] ? c[7] : c[4], 1'b0, c[0] & c[1]};
  endfunction
  // counts and reports one bit comparison
  task chk(input [8*10:1] what, input exp, input got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %0s expected %b seen %b", what, exp, got);
      end
    end
  endtask
  // prints the counts and the verdict, ends the run
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // waits, bounded, for the core reset to lift
  task waitCore;
    begin
      while (coreRstn !== 1'b1 && n < 200) begin
        @(posedge sys_clk);
        #1;
        n = n + 1;
      end
    end
  endtask
  // steady-state model of every pad and listener
  task checkModel;
    reg [3:0] eo, ev, ep;
    begin
      eo = expOe(cfg);
      ev = {cfg[9] ? cfg[14] : cfg[11], cfg[3] ? cfg[6] : cfg[5], 1'b0,
        cfg[2]};
      ep = {~(cfg[9] & cfg[16]), ~(cfg[3] & cfg[8]), 2'h3};
      for (k = 0; k < 4; k = k + 1) begin
        chk("padOe", eo[k], oe[k]);
        chk("padPull", ep[k], pull[k]);
        if (eo[k]) chk("padOut", ev[k], out[k]);
      end
      chk("dataIn", lv[0], moIn);
      chk("serial0", lv[0], rx0);
      chk("serial1", lv[1], rx1);
      chk("sclkIn", lv[2], sclkIn);
      chk("portF4In", lv[2], f4In);
      chk("rxClk", lv[3], rxClk);
      chk("portC2In", lv[3], c2In);
      chk("fault", cfg[0] & cfg[1] & ~lv[1], fault);
      chk("selected", cfg[0] & ~cfg[1] & ~lv[1], selected);
      if (!(cfg[12] & ~cfg[9])) chk("txBit", cfg[13], txBit);
      else if (eo[3] | extEn[3] | ep[3]) chk("txBit", lv[3], txBit);
    end
  endtask
  // one random configuration, held until settled, then compared
  task randStep;
    begin
      repeat (8) rnd = nextRand(rnd);
      @(posedge sys_clk);
      cfg <= rnd[16:0];
      extEn <= rnd[20:17] & ~expOe(rnd[16:0]);
      extVal <= rnd[24:21];
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      lv = level;
      @(posedge sys_clk);
      #1;
      checkModel;
    end
  endtask
  // cuts a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      results;
    end
  end
  // main sequence
  initial begin
    repeat (20) @(posedge sys_clk);
    #1;
    for (k = 0; k < 4; k = k + 1) begin
      chk("rstOe", 1'b0, oe[k]);
    end
    chk("coreRstn", 1'b0, coreRstn);
    chk("debugOff", 1'b0, debugRstn);
    @(posedge sys_clk);
    rstn <= 1'b1;
    trstn <= 1'b1;
    for (n = 0; n < 30; n = n + 1) @(posedge sys_clk);
    #1;
    chk("dataOe", 1'b0, oe[0]);
    chk("sclkPull", 1'b1, pull[2]);
    chk("rxClkOe", 1'b0, oe[3]);
    waitCore;
    chk("coreTime", n >= 64 && n <= 68, 1'b1);
    chk("bootMode", 1'b1, bootMode);
    repeat (60) randStep;
    @(posedge sys_clk);
    rstn <= 1'b0;
    bootModePin <= 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("debugKeep", 1'b1, debugRstn);
    chk("coreRstn", 1'b0, coreRstn);
    @(posedge sys_clk);
    rstn <= 1'b1;
    n = 0;
    waitCore;
    chk("coreTime", n >= 64 && n <= 68, 1'b1);
    chk("bootMode", 1'b0, bootMode);
    repeat (60) randStep;
    results;
  end
endmodule // tb_reset_and_shared_pin_ownership

bind reset_and_shared_pin_ownership reset_pin_checker chk_i (.sys_clk,
  .rstn, .trstn, .coreRstn, .debugRstn, .spi1Enable, .spi1Master,
  .spi1MasterOutSlaveInOut, .spiClockGpioSel, .portFBit4PullupOff,
  .spiClockPadIn, .spiClockIn, .dataPadOut, .dataPadOe, .selectPadOe,
  .spiClockPadPullupEn);
